// ==== logic/twr_pkg.sv ====
`default_nettype none
package twr_pkg;
   // ------------------------------------------------------------
   // bus address and data layout
   // ------------------------------------------------------------
   localparam logic [5:0] DEV_ADDR_HI  = 6'h26;
   localparam int         REG_AW       = 8;
   localparam int         DATA_W       = 8;
   localparam logic [2:0] LAST_BIT     = 3'h7;
   localparam logic [2:0] FIRST_BIT    = 3'h0;
   localparam int         RW_BIT       = 0;

   // ------------------------------------------------------------
   // filtered pin vector layout
   // ------------------------------------------------------------
   localparam int         PIN_W        = 3;
   localparam int         PIN_SCL      = 0;
   localparam int         PIN_SDA      = 1;
   localparam int         PIN_SEL      = 2;

   // ------------------------------------------------------------
   // timing, in crystal clock periods
   // ------------------------------------------------------------
   localparam int         DEGLITCH_CYC = 3;
   localparam int         POR_CYC      = 524288;

   typedef enum logic [8:0] {
      ST_IDLE     = 9'h001,
      ST_ADDR     = 9'h002,
      ST_ADDR_ACK = 9'h004,
      ST_PTR      = 9'h008,
      ST_PTR_ACK  = 9'h010,
      ST_WDATA    = 9'h020,
      ST_WR_ACK   = 9'h040,
      ST_RDATA    = 9'h080,
      ST_RD_ACK   = 9'h100
   } twr_state_t;
endpackage : twr_pkg
`default_nettype wire

// ==== logic/twr_deglitch.sv ====
`default_nettype none
module twr_deglitch
   import twr_pkg::*;
#(
   parameter int W = PIN_W,
   parameter int N = DEGLITCH_CYC
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] hist_q [N];
   logic [W-1:0] allOne;
   logic [W-1:0] allZero;

   if (N < 1 || W < 1) begin : g_chk
      $error("twr_deglitch: W and N must be at least one");
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '1;
         s2_q <= '1;
         for (int i = 0; i < N; i++) hist_q[i] <= '1;
      end else begin
         s1_q      <= din;
         s2_q      <= s1_q;
         hist_q[0] <= s2_q;
         for (int i = 1; i < N; i++) hist_q[i] <= hist_q[i-1];
      end
   end

   always_comb begin
      allOne  = '1;
      allZero = '1;
      for (int i = 0; i < N; i++) begin
         allOne  = allOne & hist_q[i];
         allZero = allZero & ~hist_q[i];
      end
   end

   // three period filter
   // a level moves the output only once it held for every sample
   always_ff @(posedge clk) begin
      if (rst) begin
         dout_q <= '1;
      end else begin
         dout_q <= (dout_q | allOne) & ~allZero;
      end
   end

   a_filter_rise: assert property (@(posedge clk) disable iff (rst)
      $rose(dout_q[0]) |-> $past(s2_q[0], 2) && $past(s2_q[0], 3) && $past(s2_q[0], 4))
      else $error("filtered line rose without three steady samples");
endmodule : twr_deglitch
`default_nettype wire

// ==== logic/twr_cross.sv ====
`default_nettype none
module twr_cross
   import twr_pkg::*;
(
   input  wire logic              lclk,
   input  wire logic              lrst,
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic [REG_AW-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData,
   output logic                   busy,
   output logic      [DATA_W-1:0] doneData_q,
   input  wire logic              clk,
   input  wire logic              sys_rst,
   output logic      [REG_AW-1:0] regAddr_q,
   output logic      [DATA_W-1:0] regWrData_q,
   output logic                   regWrStrobe_q,
   output logic                   regRdStrobe_q,
   input  wire logic [DATA_W-1:0] regRdData
);
   // ------------------------------------------------------------
   // link side: toggle request, bundle held until acknowledged
   // ------------------------------------------------------------
   logic              reqTgl_q;
   logic              wr_q;
   logic [REG_AW-1:0] addr_q;
   logic [DATA_W-1:0] data_q;
   logic              ackS1_q, ackS2_q, ackS3_q;
   logic              ackTgl_q;
   logic [DATA_W-1:0] rdData_q;

   assign busy = reqTgl_q ^ ackS3_q;

   always_ff @(posedge lclk) begin
      if (lrst) begin
         reqTgl_q <= 1'b0;
         wr_q     <= 1'b0;
         addr_q   <= '0;
         data_q   <= '0;
      end else if (reqValid && !busy) begin
         reqTgl_q <= ~reqTgl_q;
         wr_q     <= reqWrite;
         addr_q   <= reqAddr;
         data_q   <= reqData;
      end
   end

   always_ff @(posedge lclk) begin
      if (lrst) begin
         ackS1_q    <= 1'b0;
         ackS2_q    <= 1'b0;
         ackS3_q    <= 1'b0;
         doneData_q <= '0;
      end else begin
         ackS1_q <= ackTgl_q;
         ackS2_q <= ackS1_q;
         ackS3_q <= ackS2_q;
         if (ackS2_q ^ ackS3_q) doneData_q <= rdData_q;
      end
   end

   // ------------------------------------------------------------
   // system side: strobe out, sample read data one cycle later
   // ------------------------------------------------------------
   logic reqS1_q, reqS2_q, reqS3_q;
   logic rdPend_q;
   logic newReq;

   assign newReq = reqS2_q ^ reqS3_q;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reqS1_q       <= 1'b0;
         reqS2_q       <= 1'b0;
         reqS3_q       <= 1'b0;
         regWrStrobe_q <= 1'b0;
         regRdStrobe_q <= 1'b0;
         regAddr_q     <= '0;
         regWrData_q   <= '0;
      end else begin
         reqS1_q       <= reqTgl_q;
         reqS2_q       <= reqS1_q;
         reqS3_q       <= reqS2_q;
         regWrStrobe_q <= newReq & wr_q;
         regRdStrobe_q <= newReq & ~wr_q;
         if (newReq) begin
            regAddr_q   <= addr_q;
            regWrData_q <= data_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdPend_q <= 1'b0;
         rdData_q <= '0;
         ackTgl_q <= 1'b0;
      end else begin
         rdPend_q <= newReq;
         if (rdPend_q) rdData_q <= regRdData;
         ackTgl_q <= ackTgl_q ^ rdPend_q;
      end
   end

   a_strobe_single: assert property (@(posedge clk) disable iff (sys_rst)
      (regWrStrobe_q || regRdStrobe_q) |=> !(regWrStrobe_q || regRdStrobe_q) && $changed(ackTgl_q))
      else $error("register strobe not single or not acknowledged");
endmodule : twr_cross
`default_nettype wire

// ==== logic/twr_slave.sv ====
// Notes on behaviour
// - host alone drives clock; device only pulls data low, open drain.
// - pointer advances as each returned byte is loaded for sending; sequential reads walk registers.
// - bus address is 100110 plus the address select pin as lowest bit.
// - lines idle high; nothing answered until a start is seen.
// - matching address byte is acknowledged, then data flows that direction.
// - stop or repeated start ends the transfer.
// - write bits sampled on the delayed clock rising edge.
// - clock filtered over three crystal periods against glitches.
// - read data changes only after the delayed clock falling edge.
// - first written byte after the address loads the pointer.
// - each written data byte stored at pointer, pointer then advances.
// - serial logic keeps running in standby; it has no power gating.
// - power-on count or external reset returns interface to defaults.
`default_nettype none
module twr_slave
   import twr_pkg::*;
#(
   parameter int PorCycles = POR_CYC
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              crystal_clock_input,
   input  wire logic              sclIn,
   input  wire logic              sdaIn,
   output logic                   sdaOut_q,
   output logic                   sdaOe_q,
   input  wire logic              addrSelIn,
   output wire logic [REG_AW-1:0] regAddr_q,
   output wire logic [DATA_W-1:0] regWrData_q,
   output wire logic              regWrStrobe_q,
   output wire logic              regRdStrobe_q,
   input  wire logic [DATA_W-1:0] regRdData
);
   localparam int PW = $clog2(PorCycles + 1);

   if (PorCycles < 1) begin : g_chk
      $error("twr_slave: PorCycles must be at least one");
   end

   function automatic logic [REG_AW-1:0] twr_inc(input logic [REG_AW-1:0] p);
      twr_inc = p + REG_AW'(1);
   endfunction : twr_inc

   // ------------------------------------------------------------
   // link domain reset and power-on count
   // ------------------------------------------------------------
   logic          rstS1_q, rstS2_q;
   logic [PW-1:0] porCnt_q;
   logic          porDone_q;
   logic          linkRst;

   always_ff @(posedge crystal_clock_input) begin
      rstS1_q <= sys_rst;
      rstS2_q <= rstS1_q;
   end

   always_ff @(posedge crystal_clock_input) begin
      if (rstS2_q) begin
         porCnt_q  <= '0;
         porDone_q <= 1'b0;
      end else if (!porDone_q) begin
         porCnt_q  <= porCnt_q + PW'(1);
         porDone_q <= porCnt_q == PW'(PorCycles - 1);
      end
   end

   assign linkRst = rstS2_q | ~porDone_q;

   // ------------------------------------------------------------
   // pin filtering and bus events
   // ------------------------------------------------------------
   logic [PIN_W-1:0] pins_q;
   logic             sclF, sdaF, selF;
   logic             sclP_q, sdaP_q;
   logic             sclRise, sclFall, startEv, stopEv;

   // same filter on clock, data and address select lines
   // data is delayed like the clock so hold time at the pins is kept
   twr_deglitch #(.W(PIN_W), .N(DEGLITCH_CYC)) u_filt (
      .clk    (crystal_clock_input),
      .rst    (linkRst),
      .din    ({addrSelIn, sdaIn, sclIn}),
      .dout_q (pins_q)
   );

   assign sclF = pins_q[PIN_SCL];
   assign sdaF = pins_q[PIN_SDA];
   assign selF = pins_q[PIN_SEL];

   always_ff @(posedge crystal_clock_input) begin
      if (linkRst) begin
         sclP_q <= 1'b1;
         sdaP_q <= 1'b1;
      end else begin
         sclP_q <= sclF;
         sdaP_q <= sdaF;
      end
   end

   assign sclRise = sclF & ~sclP_q;
   assign sclFall = ~sclF & sclP_q;
   assign startEv = sclF & sclP_q & ~sdaF & sdaP_q;
   assign stopEv  = sclF & sclP_q & sdaF & ~sdaP_q;

   // ------------------------------------------------------------
   // byte engine
   // ------------------------------------------------------------
   twr_state_t        state_q;
   logic [2:0]        bitCnt_q;
   logic              ackPh_q;
   logic              mAck_q;
   logic              rw_q;
   logic [DATA_W-1:0] shift_q;
   logic [REG_AW-1:0] ptr_q;
   logic [DATA_W-1:0] rdBuf;
   logic [DATA_W-1:0] rxByte;
   logic              lastBit, match, busy;
   logic              inAck, loadRd, wrByte, ptrByte, addrRead, quiet;

   always_comb begin
      rxByte   = {shift_q[DATA_W-2:0], sdaF};
      lastBit  = bitCnt_q == LAST_BIT;
      match    = rxByte[DATA_W-1:1] == {DEV_ADDR_HI, selF};
      quiet    = ~startEv & ~stopEv;
      inAck    = state_q inside {ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK};
      loadRd   = quiet & sclFall & ((state_q == ST_ADDR_ACK && ackPh_q && rw_q) ||
                                    (state_q == ST_RD_ACK && mAck_q));
      wrByte   = quiet & sclRise & lastBit & (state_q == ST_WDATA);
      ptrByte  = quiet & sclRise & lastBit & (state_q == ST_PTR);
      addrRead = quiet & sclRise & lastBit & (state_q == ST_ADDR) & match & rxByte[RW_BIT];
   end

   // no standby input: engine always clocked by the crystal
   always_ff @(posedge crystal_clock_input) begin
      if (linkRst) begin
         state_q  <= ST_IDLE;
         bitCnt_q <= FIRST_BIT;
         ackPh_q  <= 1'b0;
         mAck_q   <= 1'b0;
         rw_q     <= 1'b0;
         shift_q  <= '0;
      end else if (startEv) begin
         state_q  <= ST_ADDR;
         bitCnt_q <= FIRST_BIT;
         ackPh_q  <= 1'b0;
      end else if (stopEv) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR, ST_PTR, ST_WDATA: begin
               if (sclRise) begin
                  shift_q  <= rxByte;
                  bitCnt_q <= bitCnt_q + 3'h1;
                  ackPh_q  <= 1'b0;
                  if (lastBit) begin
                     unique case (state_q)
                        ST_ADDR: state_q <= match ? ST_ADDR_ACK : ST_IDLE;
                        ST_PTR:  state_q <= ST_PTR_ACK;
                        default: state_q <= ST_WR_ACK;
                     endcase
                     rw_q <= (state_q == ST_ADDR) ? rxByte[RW_BIT] : rw_q;
                  end
               end
            end
            ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
               if (sclFall) begin
                  ackPh_q <= ~ackPh_q;
                  if (ackPh_q) begin
                     bitCnt_q <= FIRST_BIT;
                     if (loadRd) begin
                        state_q <= ST_RDATA;
                        shift_q <= rdBuf;
                     end else begin
                        state_q <= (state_q == ST_ADDR_ACK) ? ST_PTR : ST_WDATA;
                     end
                  end
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  bitCnt_q <= bitCnt_q + 3'h1;
                  shift_q  <= {shift_q[DATA_W-2:0], 1'b0};
                  if (lastBit) state_q <= ST_RD_ACK;
               end
            end
            ST_RD_ACK: begin
               if (sclRise) mAck_q <= ~sdaF;
               if (sclFall) begin
                  bitCnt_q <= FIRST_BIT;
                  if (loadRd) begin
                     state_q <= ST_RDATA;
                     shift_q <= rdBuf;
                  end else begin
                     state_q <= ST_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // data line driver
   // ------------------------------------------------------------
   // drive changes only on delayed fall, start or stop
   always_ff @(posedge crystal_clock_input) begin
      if (linkRst || startEv || stopEv) begin
         sdaOe_q <= 1'b0;
      end else if (sclFall) begin
         if (loadRd) sdaOe_q <= ~rdBuf[DATA_W-1];
         else if (inAck) sdaOe_q <= ~ackPh_q;
         else if (state_q == ST_RDATA) sdaOe_q <= ~lastBit & ~shift_q[DATA_W-2];
         else sdaOe_q <= 1'b0;
      end
   end

   // open drain: only ever pulls low
   always_ff @(posedge crystal_clock_input) begin
      sdaOut_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // register pointer and access requests
   // ------------------------------------------------------------
   always_ff @(posedge crystal_clock_input) begin
      if (linkRst) begin
         ptr_q <= '0;
      end else if (ptrByte) begin
         ptr_q <= rxByte;
      end else if (wrByte || loadRd) begin
         ptr_q <= twr_inc(ptr_q);
      end
   end

   // read prefetch: next byte fetched while current one shifts out
   twr_cross u_cross (
      .lclk          (crystal_clock_input),
      .lrst          (linkRst),
      .reqValid      (wrByte | addrRead | loadRd),
      .reqWrite      (wrByte),
      .reqAddr       (loadRd ? twr_inc(ptr_q) : ptr_q),
      .reqData       (rxByte),
      .busy          (busy),
      .doneData_q    (rdBuf),
      .clk           (clk),
      .sys_rst       (sys_rst),
      .regAddr_q     (regAddr_q),
      .regWrData_q   (regWrData_q),
      .regWrStrobe_q (regWrStrobe_q),
      .regRdStrobe_q (regRdStrobe_q),
      .regRdData     (regRdData)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge crystal_clock_input); endclocking
   default disable iff (linkRst);

   sequence s_addr_done;
      quiet && sclRise && lastBit && state_q == ST_ADDR;
   endsequence

   sequence s_ack_fall;
      state_q == ST_ADDR_ACK && sclFall && !ackPh_q && quiet;
   endsequence

   sequence s_read_fall;
      state_q == ST_RDATA && sclFall && quiet && !lastBit;
   endsequence

   sequence s_host_nack;
      state_q == ST_RD_ACK && sclFall && quiet && !mAck_q;
   endsequence

   a_open_drain: assert property (sdaOe_q |-> !sdaOut_q)
      else $error("data line driven high");
   a_idle_silent: assert property ((state_q == ST_IDLE && !startEv) |=> !sdaOe_q)
      else $error("data driven while idle");
   a_addr_ack: assert property (s_ack_fall |=> sdaOe_q)
      else $error("own address not acknowledged");
   a_addr_match: assert property ((s_addr_done and match) |=> state_q == ST_ADDR_ACK)
      else $error("own address not taken");
   a_ack_release: assert property ((inAck && sclFall && ackPh_q && quiet && !loadRd)
      |=> !sdaOe_q)
      else $error("acknowledge not released");
   a_read_bit: assert property (s_read_fall |=> sdaOe_q == !$past(shift_q[DATA_W-2]))
      else $error("read bit not driven from shifter");
   a_nack_idle: assert property (s_host_nack |=> state_q == ST_IDLE && !sdaOe_q)
      else $error("read not ended after host nack");
   a_start_release: assert property (startEv |=> !sdaOe_q)
      else $error("data still driven after start");
   a_ptr_hold: assert property ((!ptrByte && !wrByte && !loadRd) |=> $stable(ptr_q))
      else $error("pointer moved without cause");
   a_por_hold: assert property (disable iff (1'b0) !porDone_q |=> state_q == ST_IDLE)
      else $error("engine left idle during power-on hold");
   a_addr_miss: assert property ((s_addr_done and !match) |=> state_q == ST_IDLE)
      else $error("foreign address not ignored");
   a_stop_release: assert property (stopEv |=> state_q == ST_IDLE && !sdaOe_q)
      else $error("stop did not release");
   a_restart: assert property (startEv |=> state_q == ST_ADDR && bitCnt_q == FIRST_BIT)
      else $error("start did not open address phase");
   a_drive_fall: assert property ($changed(sdaOe_q) |-> $past(sclFall || startEv || stopEv))
      else $error("data changed outside clock fall");
   a_ptr_load: assert property (ptrByte |=> ptr_q == $past(rxByte))
      else $error("pointer not loaded");
   a_ptr_write: assert property (wrByte |=> ptr_q == $past(ptr_q) + REG_AW'(1))
      else $error("pointer not advanced after write");
   a_ptr_read: assert property (loadRd |=> ptr_q == $past(ptr_q) + REG_AW'(1) ##0
      shift_q == $past(rdBuf))
      else $error("read did not advance pointer");
   a_capture_rise: assert property ((state_q == ST_PTR && $changed(shift_q)) |->
      $past(sclRise))
      else $error("write bit taken off the rising edge");
endmodule : twr_slave
`default_nettype wire

// ==== logic/twr_placeholder_none.sv ====
`default_nettype none
`default_nettype wire

// ==== test/twr_host_model.sv ====
`default_nettype none
module twr_host_model (
   output logic      sclOut,
   output logic      sdaLow,
   input  wire logic sdaWire
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sclOut = 1'b1;
      sdaLow = 1'b0;
   end
   // ------------------------------------------------------------
   // bus conditions
   // ------------------------------------------------------------
   // host owns clock
   task automatic start();
      sdaLow = 1'b0;
      // wait out the device releasing its acknowledge
      #2000;
      sclOut = 1'b1;
      #2000;
      sdaLow = 1'b1;
      #2000;
      sclOut = 1'b0;
   endtask : start
   task automatic stop();
      #1000;
      sdaLow = 1'b1;
      #2000;
      sclOut = 1'b1;
      #2000;
      sdaLow = 1'b0;
      #2000;
   endtask : stop
   // ------------------------------------------------------------
   // bit and byte
   // ------------------------------------------------------------
   // data held while high
   task automatic xfer_bit(input logic b, input logic glitch, output logic r, output logic ok);
      logic s0;
      // short pulse far below the filter length
      if (glitch) begin
         #300;
         sclOut = 1'b1;
         #100;
         sclOut = 1'b0;
      end
      #1000;
      sdaLow = !b;
      #2000;
      sclOut = 1'b1;
      #100;
      s0 = sdaWire;
      #900;
      r = sdaWire;
      #900;
      ok = (s0 === r) && (sdaWire === r);
      #100;
      sclOut = 1'b0;
   endtask : xfer_bit
   task automatic xfer_byte(input logic [7:0] tx, input logic ackIn, input logic glitch,
                            output logic [7:0] rx, output logic ack, output logic ok);
      logic r;
      logic k;
      ok = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         xfer_bit(tx[i], glitch, r, k);
         rx[i] = r;
         ok = ok & k;
      end
      xfer_bit(ackIn, 1'b0, ack, k);
   endtask : xfer_byte
endmodule : twr_host_model
`default_nettype wire

// ==== test/tb_top.sv ====
`default_nettype none
module tb_top;
   import twr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PorCyc = 4;
   logic        clk, sysRst, xtal, addrSel, sdaOut, sdaOe, wrStb, rdStb, sclPin, hostLow;
   logic [7:0]  rdQ [$];
   logic [7:0]  regAddr, wrData, rdData, junk;
   logic [7:0]  mem [256];
   logic [7:0]  expMem [256];
   logic [15:0] wrQ [$];
   logic        b0;
   wire  logic  sdaWire;
   int          error_cnt, checks_done, cycles;
   int          seed = 32'ha379;
   // pull-up on the shared data line
   assign sdaWire = (sdaOe || hostLow) ? 1'b0 : 1'b1;
   assign rdData = mem[regAddr];
   twr_slave #(.PorCycles(PorCyc)) twr_slave_i (
      .clk(clk), .sys_rst(sysRst), .crystal_clock_input(xtal), .sclIn(sclPin),
      .sdaIn(sdaWire), .sdaOut_q(sdaOut), .sdaOe_q(sdaOe), .addrSelIn(addrSel),
      .regAddr_q(regAddr), .regWrData_q(wrData), .regWrStrobe_q(wrStb),
      .regRdStrobe_q(rdStb), .regRdData(rdData)
   );
   twr_host_model host_i (.sclOut(sclPin), .sdaLow(hostLow), .sdaWire(sdaWire));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // link clock free running, phase unrelated
   initial begin
      xtal = 1'b0;
      #37;
      forever #80 xtal = ~xtal;
   end
   // ------------------------------------------------------------
   // compare and verdict
   // ------------------------------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic give_verdict();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict
   // watcher: every write strobe must match the oldest note
   // strobes launch on the rising edge, so look on the falling one
   always @(negedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         error_cnt++;
         give_verdict();
      end
      if (sdaOe === 1'b1) chk(16'(sdaOut), 16'h0000);
      if (wrStb === 1'b1) begin
         chk(16'(wrQ.size() > 0), 16'h0001);
         if (wrQ.size() > 0) chk({regAddr, wrData}, wrQ.pop_front());
         mem[regAddr] = wrData;
      end
      if (rdStb === 1'b1) begin
         chk(16'(rdQ.size() > 0), 16'h0001);
         if (rdQ.size() > 0) chk(16'(regAddr), 16'(rdQ.pop_front()));
      end
   end
   // ------------------------------------------------------------
   // transfers
   // ------------------------------------------------------------
   task automatic wr(input logic [7:0] b, input logic hit, input logic g);
      logic [7:0] rx;
      logic       ack;
      logic       ok;
      host_i.xfer_byte(b, 1'b1, g, rx, ack, ok);
      chk(16'(ack), 16'(!hit));
   endtask : wr
   task automatic wr_seq(input logic [7:0] dev, input logic hit, input logic [7:0] p,
                         input int n);
      logic [7:0] d;
      host_i.start();
      wr(dev, hit, 1'b0);
      if (hit) begin
         wr(p, 1'b1, 1'b0);
         for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            wrQ.push_back({p + 8'(i), d});
            expMem[p + 8'(i)] = d;
            wr(d, 1'b1, i == 1);
         end
      end
      host_i.stop();
   endtask : wr_seq
   task automatic rd_seq(input logic [7:0] dev, input logic [7:0] p, input int n);
      logic [7:0] rx;
      logic       ack;
      logic       ok;
      // prefetch fetches one register past the last byte read
      for (int i = 0; i <= n; i++) rdQ.push_back(p + 8'(i));
      host_i.start();
      wr(dev, 1'b1, 1'b0);
      wr(p, 1'b1, 1'b0);
      // direction turned by a repeated start
      host_i.start();
      wr(dev | 8'h01, 1'b1, 1'b0);
      for (int i = 0; i < n; i++) begin
         host_i.xfer_byte(8'hFF, i == n - 1, 1'b0, rx, ack, ok);
         chk(16'(rx), 16'(expMem[p + 8'(i)]));
         chk(16'(ok), 16'h0001);
      end
      host_i.stop();
   endtask : rd_seq
   task automatic do_reset();
      @(posedge clk);
      #5;
      sysRst = 1'b1;
      repeat (8) @(posedge clk);
      #5;
      chk({regAddr, 7'h00, sdaOe}, 16'h0000);
      sysRst = 1'b0;
      repeat (60) @(posedge clk);
   endtask : do_reset
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      sysRst = 1'b1;
      addrSel = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      cycles = 0;
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($random(seed));
         expMem[i] = mem[i];
      end
      do_reset();
      wr_seq(8'h9C, 1'b0, 8'h00, 0);
      wr_seq(8'h98, 1'b1, 8'($random(seed)), 3);
      @(posedge clk);
      #5;
      addrSel = 1'b1;
      #5000;
      wr_seq(8'h98, 1'b0, 8'h00, 0);
      wr_seq(8'h9A, 1'b1, 8'hFE, 2);
      rd_seq(8'h9A, 8'hFE, 3);
      @(posedge clk);
      #5;
      addrSel = 1'b0;
      #5000;
      rd_seq(8'h98, 8'h00, 28);
      // partial byte before stop is thrown away
      host_i.start();
      wr(8'h98, 1'b1, 1'b0);
      wr(8'h10, 1'b1, 1'b0);
      repeat (4) host_i.xfer_bit(1'b0, 1'b0, b0, b0);
      host_i.stop();
      rd_seq(8'h98, 8'h10, 1);
      // byte cut short by a stop, then reset with the bus idle
      host_i.start();
      wr(8'h98, 1'b1, 1'b0);
      wr(8'h20, 1'b1, 1'b0);
      repeat (3) host_i.xfer_bit(1'b1, 1'b0, b0, b0);
      host_i.stop();
      do_reset();
      wr_seq(8'h98, 1'b1, 8'h30, 1);
      repeat (50) @(posedge clk);
      chk(16'(wrQ.size()), 16'h0000);
      chk(16'(rdQ.size()), 16'h0000);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
